// ---- rtl/mapc_card.sv ----
/*
 * multi-axis position card: quadrature counters, speed set values,
 * touch-probe capture, status bytes and the read watchdog.
 * assumes a host on the plain register port, inputs synchronous to
 * nothing (they are synchronised here) and one 125 MHz clock.
 */
`timescale 1ns/1ns

// Summary of operation
// - slave only, never starts bus transfers
// - two or four identical axis channels
// - quadrature tracks give count direction
// - sixteen bit counter wraps, no carry
// - tracks up to 1 MHz counted
// - reading actual value leaves counter unchanged
// - zero mark clears counter during search
// - reset clears every position counter
// - host writes sixteen bit speed set value
// - set value drives converter as signed code
// - reset clears every speed set value
// - probe edge captures all axes together
// - software trigger captures all axes together
// - status shows malfunction, breaks, watchdog
// - host must read within watchdog timeout
// - watchdog clears set values, sets status
// - watchdog indication latching or following
// - lamp on until watchdog fires
// - address selects axis and function
// - watchdog flag sits in status bit seven
// - actual read re-arms non-latching watchdog
module mapc_card #(
    parameter int NUM_AXES       = 4,                 // 2 or 4 channels
    parameter int WD_TIMEOUT_CYC = mapc_pkg::WD_CYCLES // read timeout
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // register port
    input  wire mapc_pkg::mapc_bus_t      bus,
    output logic [15:0]                   rdata,
    output logic                          bus_rdy,
    // encoders and touch probe
    input  wire mapc_pkg::mapc_enc_t [NUM_AXES-1:0] enc,
    input  wire logic                     probe,
    input  wire logic                     probe_rise_sel,
    // watchdog straps
    input  wire logic                     wd_clear_en,
    input  wire logic                     wd_latch_en,
    // converter codes and lamp
    output logic [NUM_AXES-1:0][15:0]     dac_code,
    output logic                          watchdog_ok_lamp
);

    // ************************************************************
    // helper functions
    // ************************************************************
    // returns {up, count}; a leading b counts up
    function automatic logic [1:0] quad_step(input logic pa, input logic pb,
                                             input logic a, input logic b);
        logic cnt;
        cnt = (a ^ pa) ^ (b ^ pb);
        quad_step = {~(pa ^ b), cnt};
    endfunction

    // true when an access hits function fn of axis ax
    function automatic logic hit(input mapc_pkg::mapc_bus_t q, input int ax,
                                 input logic [1:0] fn);
        hit = (q.addr[0] == 1'b0)
            && (int'(q.addr[mapc_pkg::AXIS_HI:mapc_pkg::AXIS_LO]) == ax)
            && (q.addr[mapc_pkg::FUNC_HI:mapc_pkg::FUNC_LO] == fn);
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    mapc_pkg::mapc_enc_t [NUM_AXES-1:0] enc_s1;       // first stage only
    mapc_pkg::mapc_enc_t [NUM_AXES-1:0] enc_s2;       // stable copy
    mapc_pkg::mapc_enc_t [NUM_AXES-1:0] enc_s3;       // previous stable
    logic [2:0]                         probe_s;      // probe pipeline

    // two flops per input, a third one for edges
    always_ff @(posedge clk) begin
        enc_s1  <= enc;
        enc_s2  <= enc_s1;
        enc_s3  <= enc_s2;
        probe_s <= {probe_s[1:0], probe};
    end

    // ************************************************************
    // decode of the register port
    // ************************************************************
    logic                probe_edge;                  // selected probe edge
    logic                sw_trig;                     // software trigger
    logic                act_read;                    // any actual read
    logic                st_write;                    // any status write
    logic [NUM_AXES-1:0][1:0] step;                   // {up, count}

    // the card only answers strobes, never drives them
    always_comb begin
        probe_edge = probe_rise_sel ? (probe_s[1] & ~probe_s[2])
                                    : (~probe_s[1] & probe_s[2]);
        sw_trig  = 1'b0;
        act_read = 1'b0;
        st_write = 1'b0;
        for (int i = 0; i < NUM_AXES; i++) begin
            // direction from phase relation
            step[i] = quad_step(enc_s3[i].a, enc_s3[i].b,
                                enc_s2[i].a, enc_s2[i].b);
            // axis and function from address bits
            if (bus.rd && hit(bus, i, mapc_pkg::FN_ACTUAL)) begin
                act_read = 1'b1;
            end
            if (bus.wr && hit(bus, i, mapc_pkg::FN_STATUS)) begin
                st_write = 1'b1;
                if (bus.wdata[mapc_pkg::ST_TRIGGER]) begin
                    sw_trig = 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // watchdog
    // ************************************************************
    mapc_pkg::mapc_wd_t            wd_state, next_wd_state;
    logic [mapc_pkg::WD_CNT_W-1:0] wd_cnt, next_wd_cnt;  // cycles since read
    logic                          wd_fired;             // indication
    logic                          wd_expired;           // count at limit

    assign wd_expired = (wd_cnt == mapc_pkg::WD_CNT_W'(WD_TIMEOUT_CYC));
    assign wd_fired   = (wd_state == mapc_pkg::MAPC_WD_FIRED);

    // latching holds until a status write; otherwise it follows reads
    always_comb begin
        next_wd_cnt   = wd_cnt;
        next_wd_state = wd_state;
        // an actual read within the timeout keeps the card alive
        if (act_read) begin
            next_wd_cnt = '0;
        end else if (!wd_expired) begin
            next_wd_cnt = wd_cnt + 1'b1;
        end
        case (wd_state)
            mapc_pkg::MAPC_WD_ARMED: begin
                if (wd_expired && !act_read) begin
                    next_wd_state = mapc_pkg::MAPC_WD_FIRED;
                end
            end
            mapc_pkg::MAPC_WD_FIRED: begin
                // release path depends on the strap
                if (wd_latch_en) begin
                    if (st_write) begin
                        next_wd_state = mapc_pkg::MAPC_WD_ARMED;
                        next_wd_cnt   = '0;
                    end
                end else if (act_read) begin
                    next_wd_state = mapc_pkg::MAPC_WD_ARMED;
                end
            end
            default: begin
                next_wd_state = mapc_pkg::MAPC_WD_FIRED;
            end
        endcase
    end

    // watchdog registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wd_state <= mapc_pkg::MAPC_WD_ARMED;
            wd_cnt   <= '0;
        end else begin
            wd_state <= next_wd_state;
            wd_cnt   <= next_wd_cnt;
        end
    end

    // ************************************************************
    // per-axis state
    // ************************************************************
    logic [NUM_AXES-1:0][15:0] pos, next_pos;         // position_counter
    logic [NUM_AXES-1:0][15:0] setp, next_setp;       // speed set value
    logic [NUM_AXES-1:0][15:0] meas, next_meas;       // measuring value
    logic [NUM_AXES-1:0]       ref_act, next_ref_act; // search running
    logic [NUM_AXES-1:0]       ref_hit, next_ref_hit; // zero mark found
    logic [NUM_AXES-1:0]       m_rdy, next_m_rdy;     // capture waiting
    logic                      capture;               // latch all axes

    // probe and software trigger share one strobe
    assign capture = probe_edge | sw_trig;

    // counter, set value, capture and flags of every axis
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            next_pos[i]     = pos[i];
            next_setp[i]    = setp[i];
            next_meas[i]    = meas[i];
            next_ref_act[i] = ref_act[i];
            next_ref_hit[i] = ref_hit[i];
            next_m_rdy[i]   = m_rdy[i];
            // plain 16 bit arithmetic wraps, no carry kept
            if (step[i][0]) begin
                next_pos[i] = step[i][1] ? pos[i] + 16'h0001
                                         : pos[i] - 16'h0001;
            end
            // status write starts or stops the search
            if (bus.wr && hit(bus, i, mapc_pkg::FN_STATUS)) begin
                next_ref_act[i] = bus.wdata[mapc_pkg::ST_REF_ACTIVE];
                if (bus.wdata[mapc_pkg::ST_REF_ACTIVE]) begin
                    next_ref_hit[i] = 1'b0;
                end
            end
            // zero mark clears during a reference search
            // placed after the write so a mark seen in the same cycle
            // as a restart still sets the reached flag
            if (ref_act[i] && enc_s2[i].z && !enc_s3[i].z) begin
                next_pos[i]     = mapc_pkg::POS_RST;
                next_ref_act[i] = 1'b0;
                next_ref_hit[i] = 1'b1;
            end
            // host owns the set value
            if (bus.wr && hit(bus, i, mapc_pkg::FN_SETVAL)) begin
                next_setp[i] = bus.wdata;
            end
            // host may preset the measuring register
            if (bus.wr && hit(bus, i, mapc_pkg::FN_MEASURE)) begin
                next_meas[i] = bus.wdata;
            end
            // reading a capture consumes it; a new capture wins
            if (bus.rd && hit(bus, i, mapc_pkg::FN_MEASURE)) begin
                next_m_rdy[i] = 1'b0;
            end
            if (capture) begin
                next_meas[i]  = pos[i];
                next_m_rdy[i] = 1'b1;
            end
            // fired watchdog holds set values at zero
            if (wd_fired && wd_clear_en) begin
                next_setp[i] = mapc_pkg::SETP_RST;
            end
        end
    end

    // axis registers; reset clears counters and set values
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                pos[i]  <= mapc_pkg::POS_RST;
                setp[i] <= mapc_pkg::SETP_RST;
                meas[i] <= mapc_pkg::MEAS_RST;
            end
            ref_act <= '0;
            ref_hit <= '0;
            m_rdy   <= '0;
        end else begin
            pos     <= next_pos;
            setp    <= next_setp;
            meas    <= next_meas;
            ref_act <= next_ref_act;
            ref_hit <= next_ref_hit;
            m_rdy   <= next_m_rdy;
        end
    end

    // ************************************************************
    // read data and ready
    // ************************************************************
    logic [15:0] next_rdata;                          // mux result

    // reads have no side effect on the counter
    always_comb begin
        next_rdata = 16'h0000;
        for (int i = 0; i < NUM_AXES; i++) begin
            if (bus.rd && hit(bus, i, mapc_pkg::FN_STATUS)) begin
                // trigger and search bits read as zero
                next_rdata[mapc_pkg::ST_REF_HIT]  = ref_hit[i];
                next_rdata[mapc_pkg::ST_MEAS_RDY] = m_rdy[i];
                next_rdata[mapc_pkg::ST_MALFUNC]  = enc_s2[i].fault;
                next_rdata[mapc_pkg::ST_BREAK_A]  = enc_s2[i].brk_a;
                next_rdata[mapc_pkg::ST_BREAK_B]  = enc_s2[i].brk_b;
                next_rdata[mapc_pkg::ST_WD_FIRED] = wd_fired;
            end
            if (bus.rd && hit(bus, i, mapc_pkg::FN_ACTUAL)) begin
                next_rdata = pos[i];
            end
            if (bus.rd && hit(bus, i, mapc_pkg::FN_SETVAL)) begin
                next_rdata = setp[i];
            end
            if (bus.rd && hit(bus, i, mapc_pkg::FN_MEASURE)) begin
                next_rdata = meas[i];
            end
        end
    end

    // data and ready one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata   <= 16'h0000;
            bus_rdy <= 1'b0;
        end else begin
            rdata   <= next_rdata;
            bus_rdy <= bus.rd | bus.wr;
        end
    end

    // signed code straight to converter lamp
    assign dac_code         = setp;
    assign watchdog_ok_lamp = ~wd_fired;

    // ************************************************************
    // assertions, checked on axis 0
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_strobe;
        bus.rd || bus.wr;
    endsequence
    property p_rdy;
        s_strobe |=> bus_rdy;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready missing");

    property p_hold;
        !step[0][0] && !capture && !(ref_act[0] && enc_s2[0].z) |=> $stable(pos[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved");

    // reset is the trigger here, so the default disable must not apply
    property p_pos_rst;
        @(posedge clk) disable iff (1'b0)
            srst |=> pos[0] == 16'h0000;
    endproperty
    a_pos_rst: assert property (p_pos_rst) else $error("pos not reset");

    property p_setp_rst;
        @(posedge clk) disable iff (1'b0)
            srst |=> setp[0] == 16'h0000 && dac_code[0] == 16'h0000;
    endproperty
    a_setp_rst: assert property (p_setp_rst) else $error("setp not reset");

    // a status write releases a latched watchdog even at the limit
    property p_fire;
        wd_expired && !act_read && !(wd_latch_en && st_write)
            |=> wd_fired ##0 !watchdog_ok_lamp;
    endproperty
    a_fire: assert property (p_fire) else $error("watchdog late");

    sequence s_fired_clr;
        wd_fired && wd_clear_en;
    endsequence
    property p_clear;
        s_fired_clr ##1 s_fired_clr |-> dac_code[0] == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("set value kept");

    property p_capture;
        capture |=> meas[0] == $past(pos[0]) && m_rdy[0];
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    property p_zero;
        ref_act[0] && enc_s2[0].z && !enc_s3[0].z |=> pos[0] == 16'h0000 && ref_hit[0];
    endproperty
    a_zero: assert property (p_zero) else $error("zero mark missed");

    property p_bit7;
        bus.rd && hit(bus, 0, mapc_pkg::FN_STATUS) |=> rdata[7] == $past(wd_fired);
    endproperty
    a_bit7: assert property (p_bit7) else $error("status bit 7 wrong");

    property p_follow;
        wd_fired && !wd_latch_en && act_read |=> !wd_fired;
    endproperty
    a_follow: assert property (p_follow) else $error("not re-armed");

endmodule

// ---- rtl/mapc_pkg.sv ----
/*
 * package of the multi-axis position card: address map, status layout,
 * reset values, watchdog timing, bus and encoder carriers.
 * assumes a single 125 MHz system clock.
 */
package mapc_pkg;

    // ************************************************************
    // clock and watchdog timing
    // ************************************************************
    localparam int CLK_MHZ     = 125;                // system clock rate
    localparam int WD_TIME_US  = 20000;              // nominal read timeout
    localparam int WD_CYCLES   = WD_TIME_US * CLK_MHZ; // timeout in cycles
    localparam int WD_CNT_W    = 25;                 // covers the 150 ms end

    // ************************************************************
    // address map: [4:3] axis, [2:1] function, [0] must be zero
    // ************************************************************
    localparam int ADDR_W      = 5;
    localparam int AXIS_HI     = 4;
    localparam int AXIS_LO     = 3;
    localparam int FUNC_HI     = 2;
    localparam int FUNC_LO     = 1;
    localparam logic [1:0] FN_STATUS = 2'h0;         // status byte
    localparam logic [1:0] FN_ACTUAL = 2'h1;         // position counter
    localparam logic [1:0] FN_SETVAL = 2'h2;         // speed set value
    localparam logic [1:0] FN_MEASURE = 2'h3;        // captured position

    // ************************************************************
    // status byte fields
    // ************************************************************
    localparam int ST_REF_ACTIVE = 0;                // write only
    localparam int ST_REF_HIT    = 1;
    localparam int ST_TRIGGER    = 2;                // write only
    localparam int ST_MEAS_RDY   = 3;
    localparam int ST_MALFUNC    = 4;
    localparam int ST_BREAK_A    = 5;
    localparam int ST_BREAK_B    = 6;
    localparam int ST_WD_FIRED   = 7;

    // ************************************************************
    // reset values and data sizes
    // ************************************************************
    localparam int DATA_W        = 16;
    localparam logic [15:0] POS_RST  = 16'h0000;
    localparam logic [15:0] SETP_RST = 16'h0000;
    localparam logic [15:0] MEAS_RST = 16'h0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        MAPC_WD_ARMED = 2'b01,                       // reads arriving in time
        MAPC_WD_FIRED = 2'b10                        // timeout seen
    } mapc_wd_t;

    typedef struct packed {
        logic              rd;                       // read strobe
        logic              wr;                       // write strobe
        logic [ADDR_W-1:0] addr;                     // word address bits
        logic [15:0]       wdata;                    // write data
    } mapc_bus_t;

    typedef struct packed {
        logic a;                                     // encoder_track_a
        logic b;                                     // encoder_track_b
        logic z;                                     // encoder_zero_mark
        logic fault;                                 // encoder malfunction
        logic brk_a;                                 // line break on track a
        logic brk_b;                                 // line break on track b
    } mapc_enc_t;

endpackage

// ---- testbench/mapc_enc_model.sv ----
/*
 * quadrature encoder model: turns step commands into two tracks.
 * assumes the bench spaces steps no closer than a 1 MHz quarter period.
 */
`timescale 1ns/1ns

// ****************************************
// encoder track generator
// ****************************************
module mapc_enc_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // step command
    input  wire logic step,
    input  wire logic dir,
    // tracks
    output logic      trk_a,
    output logic      trk_b
);
    logic [1:0] phase;                 // gray phase of the tracks

    // one quarter period per step; up means track a leads
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 2'h0;
        end else if (step) begin
            phase <= dir ? phase + 2'h1 : phase - 2'h1;
        end
    end

    // gray mapping keeps only one track changing per step
    assign trk_a = phase[1] ^ phase[0];
    assign trk_b = phase[1];
endmodule

// ---- testbench/tb_top.sv ----
/*
 * bench of the position card: register port tasks and scenario list.
 * assumes the design with four axes and a short watchdog count.
 */
`timescale 1ns/1ns

// ****************************************
// top of the bench
// ****************************************
module tb_top;
    localparam int WD = 50;                      // shortened timeout
    logic                        clk = 1'b0;     // system clock
    logic                        srst = 1'b1;    // sync reset
    mapc_pkg::mapc_bus_t         bus = '0;       // register port request
    logic [15:0]                 rdata;          // read data
    logic                        bus_rdy;        // access done
    wire mapc_pkg::mapc_enc_t [3:0] enc;         // encoder bundles
    logic [3:0]                  stp = '0;       // step commands
    logic [3:0]                  dr = '0;        // step directions
    wire [3:0]                   ta, tb;         // model tracks
    logic [3:0]                  zm = '0;        // zero marks
    logic [3:0]                  flt = '0;       // malfunction inputs
    logic [3:0]                  bka = '0;       // break on track a
    logic [3:0]                  bkb = '0;       // break on track b
    logic                        probe = 1'b0;   // touch probe
    logic                        rise = 1'b1;    // probe edge select
    logic                        wclr = 1'b0;    // clear strap
    logic                        wlat = 1'b0;    // latch strap
    logic [3:0][15:0]            dac_code;       // converter codes
    logic                        watchdog_ok_lamp;
    int                          err_total = 0;
    int                          check_count = 0;

    always #4 clk = ~clk;

    // one model per axis feeds the tracks
    for (genvar i = 0; i < 4; i++) begin : g_ax
        mapc_enc_model u_enc (.clk(clk), .srst(srst), .step(stp[i]), .dir(dr[i]),
                              .trk_a(ta[i]), .trk_b(tb[i]));
        assign enc[i] = {ta[i], tb[i], zm[i], flt[i], bka[i], bkb[i]};
    end

    mapc_card #(.NUM_AXES(4), .WD_TIMEOUT_CYC(WD)) u_dut (
        .clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .bus_rdy(bus_rdy),
        .enc(enc), .probe(probe), .probe_rise_sel(rise), .wd_clear_en(wclr),
        .wd_latch_en(wlat), .dac_code(dac_code), .watchdog_ok_lamp(watchdog_ok_lamp));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] ad(input int ax, input logic [1:0] fn);
        return {ax[1:0], fn, 1'b0};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // read: strobe one cycle, data stand only in the next cycle
    task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk({15'h0, bus_rdy}, 16'h1);
        chk(rdata & m, e);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(negedge clk);
        chk({15'h0, bus_rdy}, 16'h1);
    endtask

    // steps 33 cycles apart, 264 ns against the 250 ns quarter period of the fastest legal track rate
    task automatic mv(input int ax, input int n, input logic up);
        repeat (n) begin
            @(posedge clk);
            stp[ax] <= 1'b1;
            dr[ax] <= up;
            @(posedge clk);
            stp[ax] <= 1'b0;
            repeat (31) @(posedge clk);
        end
    endtask

    task automatic lamp(input logic e);
        chk({15'h0, watchdog_ok_lamp}, {15'h0, e});
    endtask

    task automatic conclude();
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [15:0] sv [4];
        sv = '{16'h7fff, 16'h8000, 16'h0001, 16'hffff};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        lamp(1'b1);
        for (int i = 0; i < 4; i++) begin
            chk(dac_code[i], 16'h0000);
            rc(ad(i, 2'h1), 16'hffff, 16'h0000);
        end
        // extreme and plus/minus one codes reach the converter unchanged
        for (int i = 0; i < 4; i++) begin
            wr(ad(i, 2'h2), sv[i]);
            chk(dac_code[i], sv[i]);
            rc(ad(i, 2'h2), 16'hffff, sv[i]);
        end
        // odd address is refused
        wr(5'h05, 16'h1234);
        rc(ad(0, 2'h2), 16'hffff, 16'h7fff);
        rc(5'h03, 16'hffff, 16'h0000);
        // counting both ways, wrap below zero
        mv(0, 5, 1'b1);
        mv(1, 3, 1'b1);
        mv(1, 1, 1'b0);
        mv(2, 2, 1'b0);
        repeat (4) @(posedge clk);
        rc(ad(0, 2'h1), 16'hffff, 16'h0005);
        rc(ad(0, 2'h1), 16'hffff, 16'h0005);
        rc(ad(1, 2'h1), 16'hffff, 16'h0002);
        rc(ad(2, 2'h1), 16'hffff, 16'hfffe);
        // software capture read back on axes 0 to 2
        wr(ad(0, 2'h0), 16'h0004);
        repeat (4) @(posedge clk);
        rc(ad(1, 2'h0), 16'h0008, 16'h0008);
        rc(ad(0, 2'h3), 16'hffff, 16'h0005);
        rc(ad(1, 2'h3), 16'hffff, 16'h0002);
        rc(ad(2, 2'h3), 16'hffff, 16'hfffe);
        // probe rising edge after more motion
        mv(3, 1, 1'b1);
        @(posedge clk);
        probe <= 1'b1;
        repeat (6) @(posedge clk);
        rc(ad(3, 2'h3), 16'hffff, 16'h0001);
        rc(ad(0, 2'h3), 16'hffff, 16'h0005);
        // zero mark during reference search
        wr(ad(0, 2'h0), 16'h0001);
        @(posedge clk);
        zm[0] <= 1'b1;
        repeat (6) @(posedge clk);
        zm[0] <= 1'b0;
        rc(ad(0, 2'h1), 16'hffff, 16'h0000);
        rc(ad(0, 2'h0), 16'h0002, 16'h0002);
        // fault flags, write-only bits read zero
        @(posedge clk);
        flt[3] <= 1'b1;
        bka[3] <= 1'b1;
        bkb[3] <= 1'b1;
        repeat (4) @(posedge clk);
        rc(ad(3, 2'h0), 16'hff7f, 16'h0070);
        // falling probe edge overrides a preset measuring value
        wr(ad(1, 2'h3), 16'h1234);
        rc(ad(1, 2'h3), 16'hffff, 16'h1234);
        @(posedge clk);
        rise <= 1'b0;
        probe <= 1'b0;
        repeat (6) @(posedge clk);
        rc(ad(1, 2'h3), 16'hffff, 16'h0002);
        // following watchdog: fires past the count, an actual read re-arms
        rc(ad(0, 2'h1), 16'hffff, 16'h0000);
        @(posedge clk);
        wclr <= 1'b1;
        wr(ad(1, 2'h2), 16'h0100);
        chk(dac_code[1], 16'h0100);
        repeat (WD - 12) @(negedge clk);
        lamp(1'b1);
        repeat (20) @(negedge clk);
        lamp(1'b0);
        chk(dac_code[1], 16'h0000);
        chk(dac_code[0], 16'h0000);
        rc(ad(1, 2'h0), 16'h0080, 16'h0080);
        rc(ad(0, 2'h1), 16'hffff, 16'h0000);
        repeat (2) @(negedge clk);
        lamp(1'b1);
        // latching watchdog: only a status write releases it
        @(posedge clk);
        wlat <= 1'b1;
        repeat (WD + 10) @(negedge clk);
        lamp(1'b0);
        rc(ad(0, 2'h1), 16'hffff, 16'h0000);
        lamp(1'b0);
        wr(ad(0, 2'h0), 16'h0000);
        repeat (2) @(negedge clk);
        lamp(1'b1);
        // second reset with nonzero state
        wr(ad(3, 2'h2), 16'h4000);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(dac_code[3], 16'h0000);
        rc(ad(2, 2'h1), 16'hffff, 16'h0000);
        conclude();
    end

    // hang guard, well beyond the scenario length
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule
